// ---- common/clock_path_misc_defs.svh ----
`ifndef CLOCK_PATH_MISC_DEFS_SVH
`define CLOCK_PATH_MISC_DEFS_SVH

`define OFS_MISC_CTRL 8'h17
`define OFS_TEMP_RB 8'h18
`define OFS_PATH_CFG 8'h19

`define RST_MISC_CTRL 16'h4000
`define RST_TEMP_RB 16'h0000
`define RST_PATH_CFG 16'h0211

`define MISC_TEMP_SENSOR_ENABLE 15
`define MISC_PIN_DRIVE_ENABLE 13
`define MISC_PIN_FUNCTION_SELECT 6
`define MISC_LOGIC_RANGE_HI 5
`define MISC_LOGIC_RANGE_LO 4
`define MISC_SREF3_RANGE_HI 3
`define MISC_SREF3_RANGE_LO 2
`define MISC_SREF2_RANGE_HI 1
`define MISC_SREF2_RANGE_LO 0

`define TEMP_RW_HI 13
`define TEMP_RW_LO 12
`define TEMP_VALUE_HI 11
`define TEMP_VALUE_LO 1
`define TEMP_COUNTER_ENABLE 0

`define PATH_DIV_RESET 6
`define PATH_VALUE_HI 5
`define PATH_VALUE_LO 3
`define PATH_FUNC_HI 2
`define PATH_FUNC_LO 0

`define FUNC_BUFFER 3'h1
`define FUNC_DIVIDER 3'h2
`define FUNC_MULTIPLIER 3'h3
`define MULT_MAX 3'h4
`define SREF_MODE_SYNC 2'h0

`endif

// ---- common/clock_path_misc_pkg.sv ----
package clock_path_misc_pkg;
  typedef enum logic [1:0] {
    PATH_RESERVED,
    PATH_BUFFER,
    PATH_DIVIDER,
    PATH_MULTIPLIER
  } path_func_e;
endpackage : clock_path_misc_pkg

// ---- common/main_path_if.sv ----
`timescale 1ns/1ps
`default_nettype none
interface main_path_if;
  logic [2:0] func_select;
  logic [2:0] shared_value;
  logic div_reset_bit;
  logic sync_reset_req;
  clock_path_misc_pkg::path_func_e eff_func;
  logic [3:0] div_ratio;
  logic [2:0] mult_factor;
  logic div_reset;

  modport cfg (output func_select, output shared_value, output div_reset_bit, output sync_reset_req,
               input eff_func, input div_ratio, input mult_factor, input div_reset);
  modport dec (input func_select, input shared_value, input div_reset_bit, input sync_reset_req,
               output eff_func, output div_ratio, output mult_factor, output div_reset);
endinterface : main_path_if
`default_nettype wire

// ---- design/clock_path_misc_config.sv ----
// Overview of operation
// - sensor reads valid only with both enables
// - pin driver enable: 0 high-z, 1 drive
// - pin select: 0 lock detect, 1 readback
// - three 2-bit delay range fields, code 3 reserved
// - readback bits 11:1, counter enable bit 0
// - sync request in mode 0 with sync enabled resets divider
// - divider reset ignored outside divider mode
// - function select: reserved, buffer, divider, multiplier
// - one shared divide/multiply field, bits 5:3
// - buffer mode ignores shared field
// - divide ratio value plus one; zero buffers
// - multiply factor 1 to 4, else buffer
`timescale 1ns/1ps
`default_nettype none
`include "clock_path_misc_defs.svh"
module clock_path_misc_config #(
  parameter int TEMP_WIDTH = 11
) (
  input wire logic i_ref_clk,
  input wire logic i_reset_n,
  input wire logic [7:0] i_reg_addr,
  input wire logic [15:0] i_reg_wdata,
  input wire logic i_reg_write,
  input wire logic i_reg_read,
  output logic [15:0] o_reg_rdata,
  output logic o_reg_rvalid,
  input wire logic i_lock_detect,
  input wire logic i_readback_bit,
  input wire logic [TEMP_WIDTH-1:0] i_temp_code,
  input wire logic i_sref_sync_pulse,
  input wire logic [1:0] i_sref_request_mode,
  input wire logic i_sync_enable,
  output logic o_temp_sensor_power_enable,
  output logic o_temp_counter_enable,
  output logic o_monitor_pin,
  output logic o_monitor_pin_oe,
  output logic [1:0] o_logic_sref_delay_range,
  output logic [1:0] o_sref3_delay_range,
  output logic [1:0] o_sref2_delay_range,
  output clock_path_misc_pkg::path_func_e o_main_path_function,
  output logic [3:0] o_main_div_ratio,
  output logic [2:0] o_main_multiply_value,
  output logic o_main_div_reset
);
  logic [15:0] misc_ff, nxt_misc;
  logic [1:0] temp_rw_ff, nxt_temp_rw;
  logic temp_counter_enable_ff, nxt_temp_counter_enable;
  logic [TEMP_WIDTH-1:0] temp_value_ff, nxt_temp_value;
  logic [15:0] path_ff, nxt_path;
  logic [15:0] rdata_ff, nxt_rdata;
  logic rvalid_ff, nxt_rvalid;
  logic pin_ff, nxt_pin;
  logic pin_oe_ff, nxt_pin_oe;
  logic [15:0] temp_view;

  main_path_if mp ();

  always_comb begin
    // bits 15:14 read as zero, 13:12 plain storage
    temp_view = {2'h0, temp_rw_ff, temp_value_ff, temp_counter_enable_ff};
    nxt_misc = misc_ff;
    nxt_temp_rw = temp_rw_ff;
    nxt_temp_counter_enable = temp_counter_enable_ff;
    nxt_path = path_ff;
    nxt_temp_value = temp_value_ff;
    if (i_reg_write) begin
      case (i_reg_addr)
        `OFS_MISC_CTRL: begin
          nxt_misc = i_reg_wdata;
        end
        `OFS_TEMP_RB: begin
          nxt_temp_rw = i_reg_wdata[`TEMP_RW_HI:`TEMP_RW_LO];
          nxt_temp_counter_enable = i_reg_wdata[`TEMP_COUNTER_ENABLE];
        end
        `OFS_PATH_CFG: begin
          nxt_path = i_reg_wdata;
        end
        default: begin
          nxt_misc = misc_ff;
        end
      endcase
    end
    // a sample is taken only while sensor and counter both run
    if (misc_ff[`MISC_TEMP_SENSOR_ENABLE] && temp_counter_enable_ff) begin
      nxt_temp_value = i_temp_code;
    end
    nxt_rvalid = i_reg_read;
    nxt_rdata = rdata_ff;
    if (i_reg_read) begin
      case (i_reg_addr)
        `OFS_MISC_CTRL: nxt_rdata = misc_ff;
        `OFS_TEMP_RB: nxt_rdata = temp_view;
        `OFS_PATH_CFG: nxt_rdata = path_ff;
        default: nxt_rdata = 16'h0000;
      endcase
    end
    nxt_pin_oe = misc_ff[`MISC_PIN_DRIVE_ENABLE];
    nxt_pin = misc_ff[`MISC_PIN_FUNCTION_SELECT] ? i_readback_bit : i_lock_detect;
  end

  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      misc_ff <= `RST_MISC_CTRL;
      temp_rw_ff <= 2'h0;
      temp_counter_enable_ff <= 1'b0;
      temp_value_ff <= '0;
      path_ff <= `RST_PATH_CFG;
      rdata_ff <= 16'h0000;
      rvalid_ff <= 1'b0;
      pin_ff <= 1'b0;
      pin_oe_ff <= 1'b0;
    end else begin
      misc_ff <= nxt_misc;
      temp_rw_ff <= nxt_temp_rw;
      temp_counter_enable_ff <= nxt_temp_counter_enable;
      temp_value_ff <= nxt_temp_value;
      path_ff <= nxt_path;
      rdata_ff <= nxt_rdata;
      rvalid_ff <= nxt_rvalid;
      pin_ff <= nxt_pin;
      pin_oe_ff <= nxt_pin_oe;
    end
  end

  assign mp.func_select = path_ff[`PATH_FUNC_HI:`PATH_FUNC_LO];
  assign mp.shared_value = path_ff[`PATH_VALUE_HI:`PATH_VALUE_LO];
  assign mp.div_reset_bit = path_ff[`PATH_DIV_RESET];
  // sync request only counts in request mode 0 with sync enabled
  assign mp.sync_reset_req = i_sref_sync_pulse && (i_sref_request_mode == `SREF_MODE_SYNC) && i_sync_enable;

  main_path_decode u_decode (
    .i_ref_clk(i_ref_clk),
    .i_reset_n(i_reset_n),
    .mp(mp)
  );

  assign o_reg_rdata = rdata_ff;
  assign o_reg_rvalid = rvalid_ff;
  assign o_temp_sensor_power_enable = misc_ff[`MISC_TEMP_SENSOR_ENABLE];
  assign o_temp_counter_enable = temp_counter_enable_ff;
  assign o_monitor_pin = pin_ff;
  assign o_monitor_pin_oe = pin_oe_ff;
  // code 3 is passed on unchanged; the delay generator treats it as reserved
  assign o_logic_sref_delay_range = misc_ff[`MISC_LOGIC_RANGE_HI:`MISC_LOGIC_RANGE_LO];
  assign o_sref3_delay_range = misc_ff[`MISC_SREF3_RANGE_HI:`MISC_SREF3_RANGE_LO];
  assign o_sref2_delay_range = misc_ff[`MISC_SREF2_RANGE_HI:`MISC_SREF2_RANGE_LO];
  assign o_main_path_function = mp.eff_func;
  assign o_main_div_ratio = mp.div_ratio;
  assign o_main_multiply_value = mp.mult_factor;
  assign o_main_div_reset = mp.div_reset;

  a_temp_update_both: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
    (misc_ff[`MISC_TEMP_SENSOR_ENABLE] && temp_counter_enable_ff) |=> temp_value_ff == $past(i_temp_code))
    else $error("temperature not sampled with both enables");
  a_temp_hold_idle: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
    !(misc_ff[`MISC_TEMP_SENSOR_ENABLE] && temp_counter_enable_ff) |=> $stable(temp_value_ff))
    else $error("temperature changed while not counting");
  a_pin_drive_follow: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
    ##1 o_monitor_pin_oe == $past(misc_ff[`MISC_PIN_DRIVE_ENABLE]))
    else $error("monitor pin enable does not follow its bit");
  a_pin_source_select: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
    ##1 o_monitor_pin == ($past(misc_ff[`MISC_PIN_FUNCTION_SELECT]) ? $past(i_readback_bit) : $past(i_lock_detect)))
    else $error("monitor pin source wrong");
  a_range_write_through: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
    (i_reg_write && i_reg_addr == `OFS_MISC_CTRL) |=> o_sref2_delay_range == $past(i_reg_wdata[1:0])
    && o_sref3_delay_range == $past(i_reg_wdata[3:2]) && o_logic_sref_delay_range == $past(i_reg_wdata[5:4]))
    else $error("delay range fields misplaced");
  a_readback_layout: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
    (i_reg_read && !i_reg_write && i_reg_addr == `OFS_TEMP_RB) |=> o_reg_rvalid
    && o_reg_rdata == {2'h0, $past(temp_rw_ff), $past(temp_value_ff), $past(temp_counter_enable_ff)})
    else $error("temperature register read layout wrong");
  a_sync_div_reset: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
    (i_sref_sync_pulse && i_sref_request_mode == 2'h0 && i_sync_enable
    && path_ff[`PATH_FUNC_HI:`PATH_FUNC_LO] == `FUNC_DIVIDER) |=> o_main_div_reset)
    else $error("sync request did not reset divider");
  a_bit_div_reset: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
    (path_ff[`PATH_DIV_RESET] && path_ff[`PATH_FUNC_HI:`PATH_FUNC_LO] == `FUNC_DIVIDER) |=> o_main_div_reset)
    else $error("divider reset bit ignored in divider mode");
  a_misc_read_value: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
    (i_reg_read && i_reg_addr == `OFS_MISC_CTRL)
    |=> o_reg_rvalid && o_reg_rdata == $past(misc_ff))
    else $error("misc register read wrong");
  a_path_read_value: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
    (i_reg_read && i_reg_addr == `OFS_PATH_CFG)
    |=> o_reg_rvalid && o_reg_rdata == $past(path_ff))
    else $error("path config register read wrong");
  a_counter_enable_write: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
    (i_reg_write && i_reg_addr == `OFS_TEMP_RB)
    |=> o_temp_counter_enable == $past(i_reg_wdata[`TEMP_COUNTER_ENABLE]))
    else $error("counter enable bit not stored");
  a_power_enable_write: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
    (i_reg_write && i_reg_addr == `OFS_MISC_CTRL)
    |=> o_temp_sensor_power_enable == $past(i_reg_wdata[`MISC_TEMP_SENSOR_ENABLE]))
    else $error("sensor power enable bit not stored");
  a_sync_mode_gate: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
    (!path_ff[`PATH_DIV_RESET]
    && !(i_sref_sync_pulse && i_sref_request_mode == `SREF_MODE_SYNC && i_sync_enable)) |=> !o_main_div_reset)
    else $error("divider reset without a qualifying request");
  a_reserved_function: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
    (path_ff[`PATH_FUNC_HI:`PATH_FUNC_LO] == 3'h0 || path_ff[`PATH_FUNC_HI:`PATH_FUNC_LO] > `FUNC_MULTIPLIER)
    |=> o_main_path_function == clock_path_misc_pkg::PATH_RESERVED)
    else $error("reserved function code not flagged");
  a_range_hold_steady: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
    !(i_reg_write && i_reg_addr == `OFS_MISC_CTRL)
    |=> $stable({o_logic_sref_delay_range, o_sref3_delay_range, o_sref2_delay_range}))
    else $error("delay range changed without a write");
  a_div_ratio_output: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
    (path_ff[`PATH_FUNC_HI:`PATH_FUNC_LO] == `FUNC_DIVIDER && path_ff[`PATH_VALUE_HI:`PATH_VALUE_LO] != 3'h0)
    |=> o_main_div_ratio == {1'b0, $past(path_ff[`PATH_VALUE_HI:`PATH_VALUE_LO])} + 4'h1)
    else $error("divider ratio output wrong");
  a_mult_factor_output: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
    (path_ff[`PATH_FUNC_HI:`PATH_FUNC_LO] == `FUNC_MULTIPLIER && path_ff[`PATH_VALUE_HI:`PATH_VALUE_LO] != 3'h0
    && path_ff[`PATH_VALUE_HI:`PATH_VALUE_LO] <= `MULT_MAX)
    |=> o_main_multiply_value == $past(path_ff[`PATH_VALUE_HI:`PATH_VALUE_LO]))
    else $error("multiply factor output wrong");
  c_divider_max: cover property (@(posedge i_ref_clk) disable iff (!i_reset_n)
    o_main_path_function == clock_path_misc_pkg::PATH_DIVIDER && o_main_div_ratio == 4'h8);
  c_temp_counting: cover property (@(posedge i_ref_clk) disable iff (!i_reset_n)
    misc_ff[`MISC_TEMP_SENSOR_ENABLE] && temp_counter_enable_ff ##1 !temp_counter_enable_ff);
  c_div_reset_pulse: cover property (@(posedge i_ref_clk) disable iff (!i_reset_n)
    !o_main_div_reset ##1 o_main_div_reset ##1 !o_main_div_reset);
  c_pin_readback: cover property (@(posedge i_ref_clk) disable iff (!i_reset_n)
    o_monitor_pin_oe && misc_ff[`MISC_PIN_FUNCTION_SELECT]);
endmodule : clock_path_misc_config
`default_nettype wire

// ---- design/main_path_decode.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "clock_path_misc_defs.svh"
module main_path_decode (
  input wire logic i_ref_clk,
  input wire logic i_reset_n,
  main_path_if.dec mp
);
  clock_path_misc_pkg::path_func_e func_ff, nxt_func;
  logic [3:0] ratio_ff, nxt_ratio;
  logic [2:0] factor_ff, nxt_factor;
  logic div_rst_ff, nxt_div_rst;

  always_comb begin
    nxt_func = clock_path_misc_pkg::PATH_RESERVED;
    nxt_ratio = 4'h1;
    nxt_factor = 3'h1;
    case (mp.func_select)
      `FUNC_BUFFER: begin
        nxt_func = clock_path_misc_pkg::PATH_BUFFER;
      end
      `FUNC_DIVIDER: begin
        if (mp.shared_value == 3'h0) begin
          nxt_func = clock_path_misc_pkg::PATH_BUFFER;
        end else begin
          nxt_func = clock_path_misc_pkg::PATH_DIVIDER;
          nxt_ratio = {1'b0, mp.shared_value} + 4'h1;
        end
      end
      `FUNC_MULTIPLIER: begin
        if (mp.shared_value != 3'h0 && mp.shared_value <= `MULT_MAX) begin
          nxt_func = clock_path_misc_pkg::PATH_MULTIPLIER;
          nxt_factor = mp.shared_value;
        end else begin
          nxt_func = clock_path_misc_pkg::PATH_BUFFER;
        end
      end
      default: begin
        nxt_func = clock_path_misc_pkg::PATH_RESERVED;
      end
    endcase
    // reset only reaches the divider when the divider function is chosen
    nxt_div_rst = (mp.func_select == `FUNC_DIVIDER) && (mp.div_reset_bit || mp.sync_reset_req);
  end

  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      func_ff <= clock_path_misc_pkg::PATH_BUFFER;
      ratio_ff <= 4'h1;
      factor_ff <= 3'h1;
      div_rst_ff <= 1'b0;
    end else begin
      func_ff <= nxt_func;
      ratio_ff <= nxt_ratio;
      factor_ff <= nxt_factor;
      div_rst_ff <= nxt_div_rst;
    end
  end

  assign mp.eff_func = func_ff;
  assign mp.div_ratio = ratio_ff;
  assign mp.mult_factor = factor_ff;
  assign mp.div_reset = div_rst_ff;

  a_div_ratio_value: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
    (mp.func_select == `FUNC_DIVIDER && mp.shared_value != 3'h0)
    |=> (func_ff == clock_path_misc_pkg::PATH_DIVIDER && ratio_ff == {1'b0, $past(mp.shared_value)} + 4'h1))
    else $error("divider ratio not value plus one");
  a_div_zero_buffer: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
    (mp.func_select == `FUNC_DIVIDER && mp.shared_value == 3'h0) |=> func_ff == clock_path_misc_pkg::PATH_BUFFER)
    else $error("divider value zero did not fall back to buffer");
  a_mult_range_check: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
    (mp.func_select == `FUNC_MULTIPLIER) |=>
    ((func_ff == clock_path_misc_pkg::PATH_MULTIPLIER) == ($past(mp.shared_value) inside {[3'h1:3'h4]})))
    else $error("multiplier range decode wrong");
  a_buffer_ignores_value: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
    (mp.func_select == `FUNC_BUFFER) |=> (func_ff == clock_path_misc_pkg::PATH_BUFFER && ratio_ff == 4'h1
    && factor_ff == 3'h1))
    else $error("buffer mode used the shared value");
  a_div_reset_gate: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
    (mp.func_select != `FUNC_DIVIDER) |=> !div_rst_ff)
    else $error("divider reset outside divider mode");
  c_mult_mode: cover property (@(posedge i_ref_clk) disable iff (!i_reset_n)
    func_ff == clock_path_misc_pkg::PATH_MULTIPLIER && factor_ff == 3'h4);
endmodule : main_path_decode
`default_nettype wire

// ---- test/tb_clock_path_misc_config.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "clock_path_misc_defs.svh"
module tb_clock_path_misc_config;
  logic i_ref_clk, i_reset_n, i_reg_write, i_reg_read, i_lock_detect, i_readback_bit;
  logic i_sref_sync_pulse, i_sync_enable;
  logic [7:0] i_reg_addr;
  logic [15:0] i_reg_wdata, o_reg_rdata;
  logic [10:0] i_temp_code;
  logic [1:0] i_sref_request_mode, o_logic_sref_delay_range, o_sref3_delay_range, o_sref2_delay_range;
  logic o_reg_rvalid, o_temp_sensor_power_enable, o_temp_counter_enable, o_monitor_pin, o_monitor_pin_oe;
  logic o_main_div_reset;
  clock_path_misc_pkg::path_func_e o_main_path_function, exp_func;
  logic [3:0] o_main_div_ratio, exp_ratio;
  logic [2:0] o_main_multiply_value, exp_factor;
  logic [1:0] sync_mode [3] = '{2'h0, 2'h1, 2'h0};
  logic sync_en [3] = '{1'b1, 1'b1, 1'b0};
  int n_mismatch, check_count, cycles;

  clock_path_misc_config #(.TEMP_WIDTH(11)) dut_u (
    .i_ref_clk(i_ref_clk), .i_reset_n(i_reset_n), .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata),
    .i_reg_write(i_reg_write), .i_reg_read(i_reg_read), .o_reg_rdata(o_reg_rdata), .o_reg_rvalid(o_reg_rvalid),
    .i_lock_detect(i_lock_detect), .i_readback_bit(i_readback_bit), .i_temp_code(i_temp_code),
    .i_sref_sync_pulse(i_sref_sync_pulse), .i_sref_request_mode(i_sref_request_mode),
    .i_sync_enable(i_sync_enable), .o_temp_sensor_power_enable(o_temp_sensor_power_enable),
    .o_temp_counter_enable(o_temp_counter_enable), .o_monitor_pin(o_monitor_pin),
    .o_monitor_pin_oe(o_monitor_pin_oe), .o_logic_sref_delay_range(o_logic_sref_delay_range),
    .o_sref3_delay_range(o_sref3_delay_range), .o_sref2_delay_range(o_sref2_delay_range),
    .o_main_path_function(o_main_path_function), .o_main_div_ratio(o_main_div_ratio),
    .o_main_multiply_value(o_main_multiply_value), .o_main_div_reset(o_main_div_reset)
  );

  initial begin
    i_ref_clk = 1'b0;
    forever #12.5 i_ref_clk = ~i_ref_clk;
  end

  task automatic summarize();
    if (n_mismatch == 0 && check_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : summarize

  // whole run is well under 2000 cycles
  always @(posedge i_ref_clk) begin
    cycles++;
    if (cycles == 20000) begin
      n_mismatch++;
      summarize();
    end
  end

  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge i_ref_clk);
    i_reg_addr <= a;
    i_reg_wdata <= d;
    i_reg_write <= 1'b1;
    @(posedge i_ref_clk);
    i_reg_write <= 1'b0;
  endtask : wr

  task automatic rd_chk(input logic [7:0] a, input logic [15:0] exp);
    @(posedge i_ref_clk);
    i_reg_addr <= a;
    i_reg_read <= 1'b1;
    @(posedge i_ref_clk);
    i_reg_read <= 1'b0;
    #1;
    check("rvalid", o_reg_rvalid, 16'h0001);
    check("rdata", o_reg_rdata, exp);
  endtask : rd_chk

  task automatic settle(input int n);
    repeat (n) @(posedge i_ref_clk);
    #1;
  endtask : settle

  initial begin
    i_reset_n = 1'b0;
    {i_reg_write, i_reg_read, i_lock_detect, i_readback_bit, i_sref_sync_pulse, i_sync_enable} = 6'h00;
    i_reg_addr = 8'h00;
    i_reg_wdata = 16'h0000;
    i_temp_code = 11'h000;
    i_sref_request_mode = 2'h0;
    repeat (3) @(posedge i_ref_clk);
    i_reset_n <= 1'b1;
    settle(1);
    check("func_rst", o_main_path_function, clock_path_misc_pkg::PATH_BUFFER);
    check("ratio_rst", o_main_div_ratio, 16'h0001);
    rd_chk(`OFS_MISC_CTRL, 16'h4000);
    rd_chk(`OFS_TEMP_RB, 16'h0000);
    rd_chk(`OFS_PATH_CFG, 16'h0211);
    wr(8'h20, 16'hFFFF);
    rd_chk(8'h20, 16'h0000);
    rd_chk(`OFS_MISC_CTRL, 16'h4000);
    rd_chk(`OFS_PATH_CFG, 16'h0211);
    for (int c = 0; c < 4; c++) begin
      @(posedge i_ref_clk);
      i_lock_detect <= c[0];
      i_readback_bit <= ~c[0];
      wr(`OFS_MISC_CTRL, 16'h4000 | (c[0] ? 16'h2000 : 16'h0000) | (c[1] ? 16'h0040 : 16'h0000)
        | (16'h0015 * c[1:0]));
      settle(2);
      check("pin_oe", o_monitor_pin_oe, c[0]);
      check("pin", o_monitor_pin, c[1] ? i_readback_bit : i_lock_detect);
      check("logic_range", o_logic_sref_delay_range, c[1:0]);
      check("sref3_range", o_sref3_delay_range, c[1:0]);
      check("sref2_range", o_sref2_delay_range, c[1:0]);
    end
    // sensor and counter both on, then readback captures the code
    wr(`OFS_MISC_CTRL, 16'hC000);
    wr(`OFS_TEMP_RB, 16'hFFFF);
    @(posedge i_ref_clk);
    i_temp_code <= 11'h5A5;
    settle(2);
    check("power_en", o_temp_sensor_power_enable, 16'h0001);
    check("cnt_en", o_temp_counter_enable, 16'h0001);
    rd_chk(`OFS_TEMP_RB, 16'h3B4B);
    wr(`OFS_MISC_CTRL, 16'h4000);
    @(posedge i_ref_clk);
    i_temp_code <= 11'h123;
    settle(2);
    rd_chk(`OFS_TEMP_RB, 16'h3B4B);
    // counter off before the sensor comes back, so nothing is captured
    wr(`OFS_TEMP_RB, 16'h0000);
    wr(`OFS_MISC_CTRL, 16'hC000);
    settle(2);
    rd_chk(`OFS_TEMP_RB, 16'h0B4A);
    wr(`OFS_TEMP_RB, 16'h0001);
    settle(2);
    rd_chk(`OFS_TEMP_RB, 16'h0247);
    wr(`OFS_TEMP_RB, 16'h0000);
    settle(2);
    rd_chk(`OFS_TEMP_RB, 16'h0246);
    for (int f = 0; f < 8; f++) begin
      for (int v = 0; v < 8; v++) begin
        exp_func = clock_path_misc_pkg::PATH_BUFFER;
        exp_ratio = 4'h1;
        exp_factor = 3'h1;
        if (f == 0 || f > 3) begin
          exp_func = clock_path_misc_pkg::PATH_RESERVED;
        end else if (f == 2 && v != 0) begin
          exp_func = clock_path_misc_pkg::PATH_DIVIDER;
          exp_ratio = 4'(v + 1);
        end else if (f == 3 && v >= 1 && v <= 4) begin
          exp_func = clock_path_misc_pkg::PATH_MULTIPLIER;
          exp_factor = 3'(v);
        end
        wr(`OFS_PATH_CFG, 16'h0200 | 16'(v << 3) | 16'(f));
        settle(1);
        check("func", o_main_path_function, exp_func);
        check("ratio", o_main_div_ratio, exp_ratio);
        check("factor", o_main_multiply_value, exp_factor);
      end
    end
    // value first, then reset bit high and low
    wr(`OFS_PATH_CFG, 16'h0212);
    wr(`OFS_PATH_CFG, 16'h0252);
    settle(1);
    check("div_rst_bit", o_main_div_reset, 16'h0001);
    wr(`OFS_PATH_CFG, 16'h0212);
    settle(1);
    check("div_rst_low", o_main_div_reset, 16'h0000);
    wr(`OFS_PATH_CFG, 16'h0251);
    settle(1);
    check("div_rst_buf", o_main_div_reset, 16'h0000);
    for (int m = 0; m < 4; m++) begin
      wr(`OFS_PATH_CFG, (m == 3) ? 16'h0211 : 16'h0212);
      @(posedge i_ref_clk);
      i_sref_request_mode <= sync_mode[m % 3];
      i_sync_enable <= sync_en[m % 3];
      i_sref_sync_pulse <= 1'b1;
      @(posedge i_ref_clk);
      i_sref_sync_pulse <= 1'b0;
      #1;
      check("sync_rst", o_main_div_reset, (m == 0) ? 16'h0001 : 16'h0000);
      settle(1);
      check("sync_rst_end", o_main_div_reset, 16'h0000);
    end
    summarize();
  end
endmodule : tb_clock_path_misc_config
`default_nettype wire
